// ===== design/sar_adc_defines.vh
/*
  constants for the sar converter sequencer: register field positions,
  reset values, conversion time codes and derived clock counts.
  assumes the includer works at the cpu clock rate given below.
*/
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// ----------------------------------------------------------------------------
// register fields
// ----------------------------------------------------------------------------
`define MODE_START_BIT 7
`define MODE_TSEL_HI 5
`define MODE_TSEL_LO 3
`define MODE_REF_BIT 0
`define CHAN_SEL_HI 1
`define CHAN_SEL_LO 0
`define PF_ENABLE_BIT 7
`define PF_POLARITY_BIT 6
`define MODE_RESET 8'h00
`define CHAN_RESET 8'h00
`define PF_MODE_RESET 8'h00
`define PF_THRESH_RESET 8'h00

// ----------------------------------------------------------------------------
// conversion time codes and clocks per conversion
// ----------------------------------------------------------------------------
`define TSEL_288 3'h0
`define TSEL_240 3'h1
`define TSEL_192 3'h2
`define TSEL_144 3'h4
`define TSEL_120 3'h5
`define TSEL_96 3'h6
`define CLKS_288 9'd288
`define CLKS_240 9'd240
`define CLKS_192 9'd192
`define CLKS_144 9'd144
`define CLKS_120 9'd120
`define CLKS_96 9'd96
// sample share of a conversion is one sixth; each bit gets one tenth of the rest
`define SAMPLE_DIV 9'd6
`define SAR_BITS 9'd10
`define RESULT_SHIFT 6

// ----------------------------------------------------------------------------
// reference settling (software waits, kept for reference)
// ----------------------------------------------------------------------------
`define CLK_MHZ 250
`define REF_SETTLE_US 14
`define REF_SETTLE_CLKS (`REF_SETTLE_US * `CLK_MHZ)

`endif

// ===== design/sar_bit_timer.v
/*
  per-conversion phase timer: turns a conversion time code into a sampling
  length and a per-bit decision length, and counts one phase at a time.
  assumes load_i is a single-cycle pulse from the sequencer on the same clock.
*/
`include "sar_adc_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module sar_bit_timer (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // control
  input wire [2:0] tsel_i,
  input wire load_i,
  input wire sample_phase_i,
  // status
  output reg done_o
);

  reg [8:0] total;
  reg [8:0] sample_len;
  reg [8:0] bit_len;
  reg [8:0] count;

  // ----------------------------------------------------------------------------
  // phase lengths
  // ----------------------------------------------------------------------------
  always @* begin
    case (tsel_i)
      `TSEL_288: total = `CLKS_288;
      `TSEL_240: total = `CLKS_240;
      `TSEL_192: total = `CLKS_192;
      `TSEL_144: total = `CLKS_144;
      `TSEL_120: total = `CLKS_120;
      `TSEL_96: total = `CLKS_96;
      default: total = `CLKS_288;
    endcase
    sample_len = total / `SAMPLE_DIV;
    bit_len = (total - sample_len) / `SAR_BITS;
  end

  // ----------------------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 9'h000;
      done_o <= 1'b0;
    end else if (load_i) begin
      count <= (sample_phase_i ? sample_len : bit_len) - 9'h001;
      done_o <= 1'b0;
    end else if (count != 9'h000) begin
      count <= count - 9'h001;
      done_o <= (count == 9'h001);
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule // sar_bit_timer

`default_nettype wire

// ===== design/sar_adc_sequencer_powerfail.v
/*
  sequencer for a 10-bit successive-approximation converter with four
  inputs and power-fail compare; registers are plain ports with write strobes.
  assumes the comparator output is asynchronous and is synchronised here;
  the sample-hold, tap string and analog mux are outside.
*/
// Behaviour
// - start bit set: convert repeatedly until cleared
// - sample fixed time, then hold until end
// - first trial sets bit 9, half tap
// - lower bits trialled, tap from decided bits
// - after bit 0, latch result, maybe interrupt
// - result is sar value times 64
// - register write aborts, restarts if started
// - clearing start bit stops conversion at once
// - result register undefined after reset
// - convert only the selected one of four
// - power-fail enable bit picks function
// - plain mode: store, interrupt, restart immediately
// - polarity 0: interrupt when upper >= threshold
// - polarity 1: interrupt when upper < threshold
// - result overwritten at each conversion end
// - later interrupts spaced by conversion time
// - result read completes before new result
// - mode/channel write at end wins
// - time code selects 288 to 96 clocks
`include "sar_adc_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module sar_adc_sequencer_powerfail (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // register writes
  input wire [7:0] wdata_i,
  input wire mode_wr_i,
  input wire chan_wr_i,
  input wire pf_mode_wr_i,
  input wire pf_thresh_wr_i,
  // result read strobe
  input wire result_rd_i,
  // analog side
  input wire comparator_i,
  // register contents
  output reg [7:0] converter_mode_register_o,
  output reg [7:0] channel_select_register_o,
  output reg [7:0] powerfail_mode_register_o,
  output reg [7:0] powerfail_threshold_register_o,
  output reg [15:0] conversion_result_register_o,
  // analog control
  output reg [1:0] input_select_o,
  output reg sample_o,
  output reg [9:0] tap_select_o,
  output reg reference_boost_enable_o,
  // events and status
  output reg conversion_end_interrupt_o,
  output reg busy_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SAMPLE = 2'h1;
  localparam [1:0] ST_BIT = 2'h2;
  localparam [1:0] ST_END = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] bit_idx;
  reg [9:0] sar;
  reg [9:0] next_sar;
  reg cmp_meta;
  reg cmp_sync;
  reg pending_end;
  reg [9:0] held_sar;
  reg timer_load;
  wire timer_done;
  wire any_write;
  wire start_bit;
  wire [7:0] upper;
  wire irq_cond;

  assign any_write = mode_wr_i | chan_wr_i | pf_mode_wr_i | pf_thresh_wr_i;
  assign start_bit = converter_mode_register_o[`MODE_START_BIT];
  assign upper = held_sar[9:2];
  // power-fail gate on the held result
  assign irq_cond = ~powerfail_mode_register_o[`PF_ENABLE_BIT] |
    (powerfail_mode_register_o[`PF_POLARITY_BIT] ?
      (upper < powerfail_threshold_register_o) :
      (upper >= powerfail_threshold_register_o));

  // ----------------------------------------------------------------------------
  // phase timer
  // ----------------------------------------------------------------------------
  sar_bit_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tsel_i(converter_mode_register_o[`MODE_TSEL_HI:`MODE_TSEL_LO]),
    .load_i(timer_load),
    .sample_phase_i(next_state == ST_SAMPLE),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= comparator_i;
      cmp_sync <= cmp_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      converter_mode_register_o <= `MODE_RESET;
      channel_select_register_o <= `CHAN_RESET;
      powerfail_mode_register_o <= `PF_MODE_RESET;
      powerfail_threshold_register_o <= `PF_THRESH_RESET;
    end else begin
      if (mode_wr_i)
        converter_mode_register_o <= {wdata_i[7:6] & 2'h2, wdata_i[5:0] & 6'h39};
      if (chan_wr_i)
        channel_select_register_o <= {6'h00, wdata_i[1:0]};
      if (pf_mode_wr_i)
        powerfail_mode_register_o <= {wdata_i[7:6], 6'h00};
      if (pf_thresh_wr_i)
        powerfail_threshold_register_o <= wdata_i;
    end
  end

  // ----------------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------------
  always @* begin
    next_state = state;
    next_sar = sar;
    timer_load = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_bit && !any_write) begin
          next_state = ST_SAMPLE;
          timer_load = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (timer_done) begin
          next_state = ST_BIT;
          next_sar = 10'h200;
          timer_load = 1'b1;
        end
      end
      ST_BIT: begin
        if (timer_done) begin
          // keep trial bit when input is at or above the tap
          next_sar = sar;
          if (!cmp_sync)
            next_sar[bit_idx] = 1'b0;
          if (bit_idx == 4'h0) begin
            next_state = ST_END;
          end else begin
            next_sar[bit_idx - 4'h1] = 1'b1;
            timer_load = 1'b1;
          end
        end
      end
      ST_END: begin
        next_state = ST_SAMPLE;
        timer_load = 1'b1;
      end
      default: next_state = ST_IDLE;
    endcase
    // a write or a cleared start bit abandons the conversion
    if (any_write || !start_bit) begin
      next_state = ST_IDLE;
      timer_load = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // sequencer state and analog drive
  // ----------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      sar <= 10'h000;
      bit_idx <= 4'h9;
      sample_o <= 1'b0;
      tap_select_o <= 10'h000;
      input_select_o <= 2'h0;
      reference_boost_enable_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      sar <= next_sar;
      if (next_state == ST_BIT && state == ST_SAMPLE)
        bit_idx <= 4'h9;
      else if (state == ST_BIT && timer_done && bit_idx != 4'h0)
        bit_idx <= bit_idx - 4'h1;
      sample_o <= (next_state == ST_SAMPLE);
      tap_select_o <= next_sar;
      input_select_o <= channel_select_register_o[`CHAN_SEL_HI:`CHAN_SEL_LO];
      reference_boost_enable_o <= converter_mode_register_o[`MODE_REF_BIT];
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------------
  // result transfer and interrupt
  // ----------------------------------------------------------------------------
  // result field carries no reset: its content after reset is undefined
  always @(posedge core_clk_i) begin
    if (state == ST_BIT && next_state == ST_END)
      held_sar <= next_sar;
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_end <= 1'b0;
      conversion_end_interrupt_o <= 1'b0;
    end else begin
      conversion_end_interrupt_o <= 1'b0;
      if (state == ST_BIT && next_state == ST_END) begin
        pending_end <= 1'b1;
      end else if (pending_end) begin
        // a colliding register write drops the transfer and the interrupt
        if (any_write) begin
          pending_end <= 1'b0;
        end else if (!result_rd_i) begin
          pending_end <= 1'b0;
          conversion_end_interrupt_o <= irq_cond;
        end
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (pending_end && !any_write && !result_rd_i)
      conversion_result_register_o <= {held_sar, 6'h00};
  end

endmodule // sar_adc_sequencer_powerfail

`default_nettype wire

// ===== dv/sar_analog_model.sv
/* analog side: mux, sample-hold and comparator against the tap code.
   assumes the bench sets four input levels as 10-bit codes. */
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
  // control from the sequencer
  input wire logic [1:0] sel_i,
  input wire logic sample_i,
  input wire logic [9:0] tap_i,
  // input levels, channel 0 lowest
  input wire logic [39:0] levels_i,
  // comparator
  output logic comparator_o
);
  logic [9:0] held = 10'h000;
  // tracks while sampling, keeps the last level in hold
  always @*
    if (sample_i)
      held = levels_i[sel_i*10 +: 10];
  assign comparator_o = (held >= tap_i);
endmodule // sar_analog_model
`default_nettype wire

// ===== dv/sar_adc_props.sv
/* assertions on the sequencer ports.
   assumes write strobes are one-cycle pulses. */
`timescale 1ns/100ps
`default_nettype none
module sar_adc_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // writes
  input wire logic mode_wr_i,
  input wire logic chan_wr_i,
  input wire logic pf_mode_wr_i,
  input wire logic pf_thresh_wr_i,
  // outputs
  input wire logic [7:0] converter_mode_register_o,
  input wire logic [7:0] channel_select_register_o,
  input wire logic [7:0] powerfail_mode_register_o,
  input wire logic [7:0] powerfail_threshold_register_o,
  input wire logic [15:0] conversion_result_register_o,
  input wire logic [1:0] input_select_o,
  input wire logic sample_o,
  input wire logic [9:0] tap_select_o,
  input wire logic conversion_end_interrupt_o,
  input wire logic busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] scnt;
  logic [8:0] clks;
  wire logic any_wr = mode_wr_i | chan_wr_i | pf_mode_wr_i | pf_thresh_wr_i;
  wire logic irq = conversion_end_interrupt_o;
  wire logic [7:0] powerfail_mode_register = powerfail_mode_register_o;
  wire logic [7:0] thr = powerfail_threshold_register_o;
  wire logic [7:0] upper = conversion_result_register_o[15:8];
  always_comb
    case (converter_mode_register_o[5:3])
      3'h1: clks = 9'h0F0;
      3'h2: clks = 9'h0C0;
      3'h4: clks = 9'h090;
      3'h5: clks = 9'h078;
      3'h6: clks = 9'h060;
      default: clks = 9'h120;
    endcase
  // length of the current sampling phase
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
      scnt <= 9'h000;
    else
      scnt <= sample_o ? scnt + 9'h001 : 9'h000;
  sequence s_hold_start;
    $fell(sample_o) && busy_o;
  endsequence
  a_sample_len: assert property (s_hold_start |-> scnt == clks / 9'h006)
    else $error("sampling length wrong");
  a_tap_half: assert property (s_hold_start |-> ##[0:2] tap_select_o == 10'h200)
    else $error("first trial tap wrong");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("interrupt too long");
  a_result_just: assert property (irq |-> conversion_result_register_o[5:0] == 6'h00)
    else $error("result low bits set");
  a_write_abort: assert property (any_wr && busy_o |=> !busy_o)
    else $error("write did not abort");
  a_stop_now: assert property ($fell(converter_mode_register_o[7]) |-> !busy_o)
    else $error("stop not immediate");
  a_chan_route: assert property (sample_o |-> input_select_o == channel_select_register_o[1:0])
    else $error("wrong input sampled");
  a_pf_gate: assert property (irq && powerfail_mode_register[7] |-> (powerfail_mode_register[6] ? upper < thr : upper >= thr))
    else $error("power-fail gating wrong");
endmodule // sar_adc_props
bind sar_adc_sequencer_powerfail sar_adc_props u_props (
  .core_clk_i, .rst_i, .mode_wr_i, .chan_wr_i, .pf_mode_wr_i, .pf_thresh_wr_i,
  .converter_mode_register_o, .channel_select_register_o, .powerfail_mode_register_o,
  .powerfail_threshold_register_o, .conversion_result_register_o, .input_select_o,
  .sample_o, .tap_select_o, .conversion_end_interrupt_o, .busy_o);
`default_nettype wire

// ===== dv/sar_adc_sequencer_powerfail_tb_top.sv
/* bench: register writes as one-cycle strobes, results checked
   against levels held by the analog model. */
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_powerfail_tb_top;
  localparam logic [39:0] L = {10'h3FF, 10'h200, 10'h1FF, 10'h000};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wdata_i = 8'h00;
  logic [3:0] wr_q = 4'h0;
  logic [39:0] levels = L;
  logic [7:0] mode_q, chan_q, pfm_q, thr_q;
  logic [15:0] result;
  logic [9:0] tap;
  logic [1:0] in_sel;
  logic cmp, sample, ref_en, irq, busy, e;
  logic rd = 1'b0;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  int i, c, d, p;
  always #2 core_clk_i = ~core_clk_i;
  sar_adc_sequencer_powerfail u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .wdata_i(wdata_i),
    .mode_wr_i(wr_q[0]), .chan_wr_i(wr_q[1]), .pf_mode_wr_i(wr_q[2]), .pf_thresh_wr_i(wr_q[3]),
    .result_rd_i(rd), .comparator_i(cmp), .converter_mode_register_o(mode_q),
    .channel_select_register_o(chan_q), .powerfail_mode_register_o(pfm_q),
    .powerfail_threshold_register_o(thr_q), .conversion_result_register_o(result),
    .input_select_o(in_sel), .sample_o(sample), .tap_select_o(tap),
    .reference_boost_enable_o(ref_en), .conversion_end_interrupt_o(irq), .busy_o(busy));
  sar_analog_model u_ana (.sel_i(in_sel), .sample_i(sample), .tap_i(tap), .levels_i(levels),
    .comparator_o(cmp));
  task automatic wr(input int r, input logic [7:0] v);
    wdata_i <= v;
    wr_q <= 4'h1 << r;
    @(posedge core_clk_i);
    wr_q <= 4'h0;
    @(posedge core_clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask
  function automatic int clks_of(input logic [2:0] k);
    case (k)
      3'h1: return 240;
      3'h2: return 192;
      3'h4: return 144;
      3'h5: return 120;
      3'h6: return 96;
      default: return 288;
    endcase
  endfunction
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk({mode_q, chan_q}, 16'h0000);
    chk({pfm_q, thr_q}, 16'h0000);
    chk({12'h000, busy, irq, sample, ref_en}, 16'h0000);
    // reference on, then 14 us of settling at 250 MHz before any start
    wr(0, 8'h01);
    repeat (3500) @(posedge core_clk_i);
    // every time code, channel rotating, continuous mode
    for (i = 0; i < 6; i++) begin
      c = i % 4;
      p = clks_of(codes[i]);
      levels <= L;
      wr(1, 8'(c));
      wr(0, {2'b10, codes[i], 3'h1});
      wait_irq(700, d);
      chk(result, {L[c*10 +: 10], 6'h00});
      levels <= ~L;
      wait_irq(700, d);
      chk(result, {~L[c*10 +: 10], 6'h00});
      chk(16'(d >= p && d <= p + 2), 16'h0001);
      chk({15'h0000, ref_en}, 16'h0001);
      wr(0, 8'h01);
      chk({15'h0000, busy}, 16'h0000);
    end
    wait_irq(400, d);
    chk(16'(d), 16'd400);
    // abort by a threshold write in mid-conversion
    levels <= L;
    wr(1, 8'h03);
    wr(0, 8'h81);
    repeat (100) @(posedge core_clk_i);
    wr(3, 8'h00);
    wait_irq(700, d);
    chk(16'(d > 280), 16'h0001);
    chk(result, {L[39:30], 6'h00});
    // a read held across the next end delays transfer and interrupt
    rd <= 1'b1;
    levels <= ~L;
    wait_irq(300, d);
    chk(16'(d), 16'd300);
    chk(result, {L[39:30], 6'h00});
    rd <= 1'b0;
    wait_irq(10, d);
    chk(16'(d < 10), 16'h0001);
    chk(result, {~L[39:30], 6'h00});
    wr(0, 8'h01);
    // power-fail gating at the threshold boundary, both polarities
    for (i = 0; i < 4; i++) begin
      e = i[1] ? i[0] : ~i[0];
      levels <= {4{i[0] ? 10'h1FF : 10'h200}};
      wr(3, 8'h80);
      wr(2, {1'b1, i[1], 6'h00});
      wr(1, 8'h00);
      wr(0, 8'hB1);
      wait_irq(250, d);
      chk({15'h0000, d < 250}, {15'h0000, e});
      wr(0, 8'h01);
    end
    tally_and_finish;
  end
endmodule // sar_adc_sequencer_powerfail_tb_top
`default_nettype wire
